// *** hdl/fpr_debounce.sv ***
// debounce filter with rising edge pulse
`timescale 1ns/1ps
module fpr_debounce
  import fpr_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         raw,
  input  wire logic [W-1:0] limit,
  output logic              level,
  output logic              rise
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         level_reg;
  logic         level_next;
  logic         rise_reg;
  wire          differs = (raw != level_reg);
  wire          settled = differs && (cnt_reg >= limit);

  assign cnt_next   = !differs ? '0 : (settled ? '0 : cnt_reg + W'(1));
  assign level_next = settled ? raw : level_reg;
  assign level      = level_reg;
  assign rise       = rise_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg   <= '0;
      level_reg <= 1'b0;
      rise_reg  <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      level_reg <= level_next;
      rise_reg  <= settled && raw;
    end
  end

endmodule

// *** hdl/fpr_pkg.sv ***
// package: register map, fields, reset values and timing for the front panel reset block
package fpr_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned SYSRST_HOLD_MS   = 200;
  localparam int unsigned SYSRST_HOLD_CYC  = (CLK_HZ / 1000) * SYSRST_HOLD_MS;
  localparam int unsigned DEBOUNCE_MS      = 5;
  localparam int unsigned DEBOUNCE_CYC     = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned CNT_W            = 24;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_MASK     = 8'h08;
  localparam logic [7:0] OFS_GPIN     = 8'h0C;
  localparam logic [7:0] OFS_DEBOUNCE = 8'h10;
  localparam logic [7:0] OFS_LOCMON   = 8'h14;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_ABORT_EN   = 0;
  localparam int unsigned CTRL_SYSRST_REQ = 1;
  localparam int unsigned CTRL_LOCAL_HOLD = 2;
  localparam int unsigned CTRL_LEVEL_LSB  = 4;
  localparam int unsigned LEVEL_W         = 3;

  // ----------------------------------------------------------------
  // status / mask fields
  // ----------------------------------------------------------------
  localparam int unsigned EVT_W         = 3;
  localparam int unsigned EVT_ABORT     = 0;
  localparam int unsigned EVT_SYSRST_IN = 1;
  localparam int unsigned EVT_WATCHDOG  = 2;

  // general purpose input fields
  localparam int unsigned GPIN_ABORT    = 0;
  localparam int unsigned GPIN_SYSCON   = 1;
  localparam int unsigned GPIN_SYSRST   = 2;
  localparam int unsigned GPIN_LOCALRST = 3;

  localparam int unsigned LOCMON_W = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]     CTRL_RST    = 8'h00;
  localparam logic [EVT_W-1:0] MASK_RST  = 3'h0;
  localparam logic [CNT_W-1:0] DEB_RST   = CNT_W'(DEBOUNCE_CYC);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } fpr_wb_req_t;

  typedef struct packed {
    logic failure;
    logic activity;
    logic slot_two;
    logic slot_one;
  } fpr_leds_t;

  typedef enum logic [1:0] {
    FPR_SR_IDLE = 2'b01,
    FPR_SR_HOLD = 2'b10
  } fpr_sysrst_state_t;

endpackage

// *** hdl/fpr_top.sv ***
// front panel reset, abort and status indicator logic with a wishbone register slave
//
// Summary of operation
// - enabled abort press raises processor interrupt at software programmed level.
// - abort interrupt goes out on interrupt request line eight.
// - debounced abort state is readable as general purpose input.
// - abort interrupt is edge triggered after debouncing the pushbutton.
// - reset pushbutton resets on-board devices and processor hard reset.
// - reset pushbutton drives backplane system reset only as system controller.
// - system controller asserts system reset on button, power-up, watchdog, control bit.
// - backplane system reset is held at least 200 ms once asserted.
// - software control bit holds board in local reset while set.
// - local reset works whether or not board is system controller.
// - local reset on button, power-up, watchdog, received system reset, control bit.
// - failure indicator follows board fail one clock later, off while RSTN is low.
// - activity indicator lit while data bus busy is active.
// - slot indicators follow their PCI grants, slot two upper, slot one lower.
// - on expansion carrier both slot indicators lit throughout reset.
// - outside reset carrier indicators follow secondary bus grants.
// - non system controller waits forever on missing target; another party times out.
// - four location monitor bits broadcast a signal to other boards.
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module fpr_top
  import fpr_pkg::*;
#(
  parameter int unsigned SYSRST_HOLD = SYSRST_HOLD_CYC,
  parameter int unsigned DEB_DEFAULT = DEBOUNCE_CYC
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // front panel and board inputs
  input  wire logic        ABORT_PUSHBUTTON_N,
  input  wire logic        RESET_PUSHBUTTON_N,
  input  wire logic        POWER_UP_RESET_N,
  input  wire logic        WATCHDOG_TIMEOUT,
  input  wire logic        SYSTEM_CONTROLLER,
  input  wire logic        CARRIER_PRESENT,
  input  wire logic        BOARD_FAIL_N,
  input  wire logic        DATA_BUS_BUSY_N,
  input  wire logic        PCI_GNT_SLOT_TWO_N,
  input  wire logic        PCI_GNT_SLOT_ONE_N,
  input  wire logic        SEC_GNT_SLOT_TWO_N,
  input  wire logic        SEC_GNT_SLOT_ONE_N,
  // backplane system reset, open drain
  input  wire logic        SYSRESET_N_I,
  output logic             SYSRESET_N_O,
  output logic             SYSRESET_N_OE,
  // location monitor broadcast lines
  input  wire logic [3:0]  LOCMON_I,
  output logic      [3:0]  LOCMON_O,
  // resets and interrupts
  output logic             PROCESSOR_HARD_RESET_N,
  output logic             LOCAL_RESET_N,
  output logic             IRQ8_N,
  output logic      [2:0]  IRQ_LEVEL,
  output logic             INT_O,
  // indicators
  output logic             FAILURE_INDICATOR,
  output logic             ACTIVITY_INDICATOR,
  output logic             SLOT_TWO_INDICATOR,
  output logic             SLOT_ONE_INDICATOR,
  output logic             CARRIER_SLOT_TWO_INDICATOR,
  output logic             CARRIER_SLOT_ONE_INDICATOR
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  fpr_wb_req_t            req;
  fpr_sysrst_state_t      sr_state_reg;
  fpr_sysrst_state_t      sr_state_next;
  fpr_leds_t              leds_reg;
  fpr_leds_t              leds_next;
  logic [7:0]             ctrl_reg;
  logic [EVT_W-1:0]       status_reg;
  logic [EVT_W-1:0]       status_next;
  logic [EVT_W-1:0]       mask_reg;
  logic [CNT_W-1:0]       deb_reg;
  logic [LOCMON_W-1:0]    locmon_reg;
  logic [CNT_W-1:0]       hold_cnt_reg;
  logic [CNT_W-1:0]       hold_cnt_next;
  logic [31:0]            rdata_reg;
  logic                   ack_reg;
  logic                   irq8_reg;
  logic                   local_rst_reg;
  logic                   sysrst_drv_reg;
  logic                   carrier_two_reg;
  logic                   carrier_one_reg;
  logic                   abort_level;
  logic                   abort_rise;
  logic                   wd_prev_reg;
  logic                   sys_in_prev_reg;

  assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, adr: WB_ADR_I, sel: WB_SEL_I, dat: WB_DAT_I};

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire access   = req.cyc && req.stb && !ack_reg;
  wire wr       = access && req.we;
  wire sel_ctrl = (req.adr == OFS_CTRL);
  wire sel_stat = (req.adr == OFS_STATUS);
  wire sel_mask = (req.adr == OFS_MASK);
  wire sel_gpin = (req.adr == OFS_GPIN);
  wire sel_deb  = (req.adr == OFS_DEBOUNCE);
  wire sel_lm   = (req.adr == OFS_LOCMON);
  wire wr_ctrl  = wr && sel_ctrl && req.sel[0];
  wire wr_stat  = wr && sel_stat && req.sel[0];
  wire wr_mask  = wr && sel_mask && req.sel[0];
  wire wr_lm    = wr && sel_lm && req.sel[0];
  wire [3:0] wr_deb = {4{wr && sel_deb}} & req.sel;

  wire [31:0] gpin_word = {28'h0000000, local_rst_reg, ~SYSRESET_N_I, SYSTEM_CONTROLLER, abort_level};
  logic [31:0] rdata_next;
  always_comb begin
    rdata_next = 32'h00000000;
    if (sel_ctrl) begin
      rdata_next = {24'h000000, ctrl_reg};
    end else if (sel_stat) begin
      rdata_next = {29'h00000000, status_reg};
    end else if (sel_mask) begin
      rdata_next = {29'h00000000, mask_reg};
    end else if (sel_gpin) begin
      rdata_next = gpin_word;
    end else if (sel_deb) begin
      rdata_next = {8'h00, deb_reg};
    end else if (sel_lm) begin
      rdata_next = {28'h0000000, LOCMON_I};
    end
  end

  // ----------------------------------------------------------------
  // abort pushbutton
  // ----------------------------------------------------------------
  fpr_debounce #(
    .W (CNT_W)
  ) u_abort_deb (
    .clk   (CLK_SYS),
    .rst_n (RSTN),
    .raw   (~ABORT_PUSHBUTTON_N),
    .limit (deb_reg),
    .level (abort_level),
    .rise  (abort_rise)
  );

  wire abort_evt  = abort_rise && ctrl_reg[CTRL_ABORT_EN];
  wire wd_evt     = WATCHDOG_TIMEOUT && !wd_prev_reg;
  wire sys_in_evt = !SYSRESET_N_I && !sys_in_prev_reg;
  wire [EVT_W-1:0] evt_vec = {wd_evt, sys_in_evt, abort_evt};
  wire [EVT_W-1:0] clr_vec = wr_stat ? req.dat[EVT_W-1:0] : '0;
  wire [EVT_W-1:0] mask_next = wr_mask ? req.dat[EVT_W-1:0] : mask_reg;

  // set wins over a simultaneous write-one clear
  assign status_next = (status_reg & ~clr_vec) | evt_vec;

  // ----------------------------------------------------------------
  // reset fan-out
  // ----------------------------------------------------------------
  wire button   = !RESET_PUSHBUTTON_N;
  wire power_up = !POWER_UP_RESET_N;
  wire sys_src  = button || power_up || WATCHDOG_TIMEOUT || ctrl_reg[CTRL_SYSRST_REQ];
  wire sys_trig = SYSTEM_CONTROLLER && sys_src;
  wire hold_done = (hold_cnt_reg >= CNT_W'(SYSRST_HOLD - 1));
  wire local_next = button || power_up || WATCHDOG_TIMEOUT || !SYSRESET_N_I
                    || ctrl_reg[CTRL_LOCAL_HOLD];

  always_comb begin
    sr_state_next = sr_state_reg;
    hold_cnt_next = hold_cnt_reg;
    case (sr_state_reg)
      FPR_SR_IDLE: begin
        hold_cnt_next = '0;
        if (sys_trig) begin
          sr_state_next = FPR_SR_HOLD;
        end
      end
      FPR_SR_HOLD: begin
        if (!hold_done) begin
          hold_cnt_next = hold_cnt_reg + CNT_W'(1);
        end else if (!sys_trig) begin
          sr_state_next = FPR_SR_IDLE;
        end
      end
      default: begin
        sr_state_next = FPR_SR_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // indicators
  // ----------------------------------------------------------------
  wire in_reset = local_next;
  assign leds_next = '{failure:  !BOARD_FAIL_N,
                       activity: !DATA_BUS_BUSY_N,
                       slot_two: !PCI_GNT_SLOT_TWO_N,
                       slot_one: !PCI_GNT_SLOT_ONE_N};

  // ----------------------------------------------------------------
  // clocked state
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      ctrl_reg   <= CTRL_RST;
      mask_reg   <= MASK_RST;
      status_reg <= '0;
      locmon_reg <= '0;
      ack_reg    <= 1'b0;
      rdata_reg  <= 32'h00000000;
    end else begin
      ack_reg    <= access;
      status_reg <= status_next;
      if (access) begin
        rdata_reg <= rdata_next;
      end
      if (wr_ctrl) begin
        ctrl_reg <= req.dat[7:0];
      end
      if (wr_mask) begin
        mask_reg <= req.dat[EVT_W-1:0];
      end
      if (wr_lm) begin
        locmon_reg <= req.dat[LOCMON_W-1:0];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      deb_reg <= DEB_RST;
    end else begin
      if (wr_deb[0]) deb_reg[7:0]   <= req.dat[7:0];
      if (wr_deb[1]) deb_reg[15:8]  <= req.dat[15:8];
      if (wr_deb[2]) deb_reg[23:16] <= req.dat[23:16];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      sr_state_reg    <= FPR_SR_IDLE;
      hold_cnt_reg    <= '0;
      sysrst_drv_reg  <= 1'b0;
      local_rst_reg   <= 1'b1;
      irq8_reg        <= 1'b0;
      wd_prev_reg     <= 1'b0;
      sys_in_prev_reg <= 1'b0;
      leds_reg        <= '0;
      carrier_two_reg <= 1'b1;
      carrier_one_reg <= 1'b1;
    end else begin
      sr_state_reg    <= sr_state_next;
      hold_cnt_reg    <= hold_cnt_next;
      sysrst_drv_reg  <= (sr_state_next == FPR_SR_HOLD);
      local_rst_reg   <= local_next;
      irq8_reg        <= |(status_next & mask_next & 3'h1);
      wd_prev_reg     <= WATCHDOG_TIMEOUT;
      sys_in_prev_reg <= !SYSRESET_N_I;
      leds_reg        <= leds_next;
      carrier_two_reg <= in_reset || !SEC_GNT_SLOT_TWO_N;
      carrier_one_reg <= in_reset || !SEC_GNT_SLOT_ONE_N;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign WB_ACK_O      = ack_reg;
  assign WB_DAT_O      = rdata_reg;
  assign SYSRESET_N_O  = 1'b0;
  assign SYSRESET_N_OE = sysrst_drv_reg;
  assign LOCMON_O      = locmon_reg;
  assign PROCESSOR_HARD_RESET_N = !local_rst_reg;
  assign LOCAL_RESET_N = !local_rst_reg;
  assign IRQ8_N        = !irq8_reg;
  assign IRQ_LEVEL     = ctrl_reg[CTRL_LEVEL_LSB +: LEVEL_W];
  assign INT_O         = |(status_reg & mask_reg);
  assign FAILURE_INDICATOR  = leds_reg.failure;
  assign ACTIVITY_INDICATOR = leds_reg.activity;
  assign SLOT_TWO_INDICATOR = leds_reg.slot_two;
  assign SLOT_ONE_INDICATOR = leds_reg.slot_one;
  assign CARRIER_SLOT_TWO_INDICATOR = carrier_two_reg;
  assign CARRIER_SLOT_ONE_INDICATOR = carrier_one_reg;

endmodule

// *** tb/fpr_chk.sv ***
// checker: port level assertions for the front panel reset block
`timescale 1ns/1ps
module fpr_chk
  import fpr_pkg::*;
#(
  parameter int unsigned SYSRST_HOLD = SYSRST_HOLD_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic RESET_PUSHBUTTON_N,
  input wire logic POWER_UP_RESET_N,
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic SYSTEM_CONTROLLER,
  input wire logic BOARD_FAIL_N,
  input wire logic DATA_BUS_BUSY_N,
  input wire logic PCI_GNT_SLOT_TWO_N,
  input wire logic PCI_GNT_SLOT_ONE_N,
  input wire logic SYSRESET_N_I,
  input wire logic SYSRESET_N_OE,
  input wire logic PROCESSOR_HARD_RESET_N,
  input wire logic LOCAL_RESET_N,
  input wire logic IRQ8_N,
  input wire logic INT_O,
  input wire logic FAILURE_INDICATOR,
  input wire logic ACTIVITY_INDICATOR,
  input wire logic SLOT_TWO_INDICATOR,
  input wire logic SLOT_ONE_INDICATOR
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // counts cycles the backplane reset has been driven
  logic [31:0] oe_cnt_reg;
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN || !SYSRESET_N_OE) oe_cnt_reg <= 32'h0;
    else oe_cnt_reg <= oe_cnt_reg + 32'h1;
  end
  a_ack_next:
    assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O) else $error("ack late");
  a_ack_pulse:
    assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  a_irq_int:
    assert property (!IRQ8_N |-> INT_O) else $error("irq without int");
  a_sysrst_src:
    assert property (SYSTEM_CONTROLLER && (!RESET_PUSHBUTTON_N || !POWER_UP_RESET_N || WATCHDOG_TIMEOUT)
      |=> SYSRESET_N_OE) else $error("system reset not driven");
  a_sysrst_hold:
    assert property ($fell(SYSRESET_N_OE) |-> oe_cnt_reg >= SYSRST_HOLD) else $error("system reset too short");
  a_local_src:
    assert property ((!RESET_PUSHBUTTON_N || !POWER_UP_RESET_N || WATCHDOG_TIMEOUT || !SYSRESET_N_I)
      |=> !LOCAL_RESET_N) else $error("local reset missing");
  a_hard_rst:
    assert property (!RESET_PUSHBUTTON_N |=> !PROCESSOR_HARD_RESET_N) else $error("hard reset missing");
  a_fail_led:
    assert property (##1 FAILURE_INDICATOR == !$past(BOARD_FAIL_N)) else $error("failure led wrong");
  a_act_led:
    assert property (##1 ACTIVITY_INDICATOR == !$past(DATA_BUS_BUSY_N)) else $error("activity led wrong");
  a_slot_leds:
    assert property (##1 SLOT_TWO_INDICATOR == !$past(PCI_GNT_SLOT_TWO_N)
      && SLOT_ONE_INDICATOR == !$past(PCI_GNT_SLOT_ONE_N)) else $error("slot led wrong");
endmodule

bind fpr_top fpr_chk #(.SYSRST_HOLD(SYSRST_HOLD)) fpr_chk_i (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .RESET_PUSHBUTTON_N(RESET_PUSHBUTTON_N),
  .POWER_UP_RESET_N(POWER_UP_RESET_N), .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT), .SYSTEM_CONTROLLER(SYSTEM_CONTROLLER),
  .BOARD_FAIL_N(BOARD_FAIL_N), .DATA_BUS_BUSY_N(DATA_BUS_BUSY_N), .PCI_GNT_SLOT_TWO_N(PCI_GNT_SLOT_TWO_N),
  .PCI_GNT_SLOT_ONE_N(PCI_GNT_SLOT_ONE_N), .SYSRESET_N_I(SYSRESET_N_I), .SYSRESET_N_OE(SYSRESET_N_OE),
  .PROCESSOR_HARD_RESET_N(PROCESSOR_HARD_RESET_N), .LOCAL_RESET_N(LOCAL_RESET_N), .IRQ8_N(IRQ8_N),
  .INT_O(INT_O), .FAILURE_INDICATOR(FAILURE_INDICATOR), .ACTIVITY_INDICATOR(ACTIVITY_INDICATOR),
  .SLOT_TWO_INDICATOR(SLOT_TWO_INDICATOR), .SLOT_ONE_INDICATOR(SLOT_ONE_INDICATOR));

// *** tb/fpr_top_tb.sv ***
// testbench: bus, reset, abort and indicator tests for the front panel reset block
`timescale 1ns/1ps
module fpr_top_tb
  import fpr_pkg::*;
  ;
  localparam int unsigned HOLD = 20;
  localparam logic [5:0] PAT [4] = '{6'h15, 6'h2A, 6'h3F, 6'h00};
  fpr_wb_req_t req;
  logic        clk, rstn, ack, pb_abort, syscon, line_n, oe, local_n, hard_n, irq8_n, int_o;
  logic [31:0] dout, rdat;
  logic [3:0]  src, lm_o, lm_i, peer_lm;
  logic [5:0]  led_in, leds;
  logic [2:0]  irq_lvl;
  int          mismatches = 0;
  int          total_checks = 0;

  fpr_top #(.SYSRST_HOLD(HOLD), .DEB_DEFAULT(3)) fpr_top_i (.CLK_SYS(clk), .RSTN(rstn),
    .WB_CYC_I(req.cyc), .WB_STB_I(req.stb), .WB_WE_I(req.we), .WB_ADR_I(req.adr), .WB_SEL_I(req.sel),
    .WB_DAT_I(req.dat), .WB_DAT_O(dout), .WB_ACK_O(ack), .ABORT_PUSHBUTTON_N(!pb_abort),
    .RESET_PUSHBUTTON_N(!src[0]), .POWER_UP_RESET_N(!src[1]), .WATCHDOG_TIMEOUT(src[2]),
    .SYSTEM_CONTROLLER(syscon), .CARRIER_PRESENT(1'b1), .BOARD_FAIL_N(!led_in[5]), .DATA_BUS_BUSY_N(!led_in[4]),
    .PCI_GNT_SLOT_TWO_N(!led_in[3]), .PCI_GNT_SLOT_ONE_N(!led_in[2]), .SEC_GNT_SLOT_TWO_N(!led_in[1]),
    .SEC_GNT_SLOT_ONE_N(!led_in[0]), .SYSRESET_N_I(line_n), .SYSRESET_N_O(), .SYSRESET_N_OE(oe),
    .LOCMON_I(lm_i), .LOCMON_O(lm_o), .PROCESSOR_HARD_RESET_N(hard_n), .LOCAL_RESET_N(local_n),
    .IRQ8_N(irq8_n), .IRQ_LEVEL(irq_lvl), .INT_O(int_o), .FAILURE_INDICATOR(leds[5]),
    .ACTIVITY_INDICATOR(leds[4]), .SLOT_TWO_INDICATOR(leds[3]), .SLOT_ONE_INDICATOR(leds[2]),
    .CARRIER_SLOT_TWO_INDICATOR(leds[1]), .CARRIER_SLOT_ONE_INDICATOR(leds[0]));

  fpr_vme_bp fpr_vme_bp_i (.dut_oe(oe), .peer_oe(src[3]), .dut_lm(lm_o), .peer_lm(peer_lm), .line_n(line_n),
    .lm(lm_i));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, a, 4'hF, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = dout;
    req <= '0;
    chk(n, 2);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
    wb(1'b0, a, 32'h0);
    chk(rdat & msk, exp);
  endtask
  task automatic rst_src(input int i, input logic exp_oe);
    int n;
    src <= 4'h1 << i;
    tick(2);
    chk(local_n, 1'b0);
    chk(leds[1:0], 2'b11);
    chk(oe, exp_oe);
    if (i == 0) chk(hard_n, 1'b0);
    src <= 4'h0;
    n = 0;
    while (oe === 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (exp_oe) chk(n >= HOLD && n < HOLD + 4, 1'b1);
    tick(4);
    chk(local_n, 1'b1);
  endtask
  task automatic results();
    if (mismatches == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    tick(6000);
    mismatches++;
    results();
  end
  initial begin
    rstn = 1'b0;
    req = '0;
    pb_abort = 1'b0;
    syscon = 1'b1;
    src = 4'h0;
    led_in = 6'h00;
    peer_lm = 4'h4;
    tick(19);
    chk(leds[1:0], 2'b11);
    tick(1);
    rstn <= 1'b1;
    rdc(OFS_CTRL, 32'h0, 32'hFF);
    rdc(OFS_MASK, 32'h0, 32'h7);
    rdc(OFS_DEBOUNCE, {8'h00, DEB_RST}, 32'hFFFFFF);
    rdc(OFS_GPIN, 32'h2, 32'h2);
    wr(8'h20, 32'hFFFFFFFF);
    rdc(8'h20, 32'h0, 32'hFFFFFFFF);
    wr(OFS_LOCMON, 32'hA);
    chk(lm_o, 4'hA);
    rdc(OFS_LOCMON, 32'hE, 32'hF);
    for (int k = 0; k < 4; k++) begin
      led_in <= PAT[k];
      tick(2);
      chk(leds, PAT[k]);
    end
    wr(OFS_DEBOUNCE, 32'h3);
    wr(OFS_MASK, 32'h1);
    wr(OFS_CTRL, 32'h51);
    chk(irq_lvl, 3'h5);
    pb_abort <= 1'b1;
    tick(2);
    pb_abort <= 1'b0;
    tick(8);
    chk(irq8_n, 1'b1);
    pb_abort <= 1'b1;
    tick(12);
    chk({irq8_n, int_o}, 2'b01);
    rdc(OFS_GPIN, 32'h1, 32'h1);
    wr(OFS_STATUS, 32'h1);
    tick(10);
    chk({irq8_n, int_o}, 2'b10);
    pb_abort <= 1'b0;
    tick(10);
    rdc(OFS_GPIN, 32'h0, 32'h1);
    wr(OFS_CTRL, 32'h50);
    pb_abort <= 1'b1;
    tick(12);
    rdc(OFS_STATUS, 32'h0, 32'h1);
    pb_abort <= 1'b0;
    for (int s = 1; s >= 0; s--) begin
      syscon <= s[0];
      for (int i = 0; i < 4; i++) rst_src(i, s[0] && i < 3);
    end
    rdc(OFS_STATUS, 32'h6, 32'h7);
    wr(OFS_STATUS, 32'h6);
    rdc(OFS_STATUS, 32'h0, 32'h7);
    syscon <= 1'b1;
    wr(OFS_CTRL, 32'h2);
    tick(2);
    chk(oe, 1'b1);
    wr(OFS_CTRL, 32'h4);
    tick(HOLD + 10);
    chk({oe, local_n}, 2'b00);
    wr(OFS_CTRL, 32'h0);
    tick(4);
    chk(local_n, 1'b1);
    results();
  end
endmodule

// *** tb/fpr_vme_bp.sv ***
// backplane model: wired system reset line and shared location monitor lines
`timescale 1ns/1ps
module fpr_vme_bp (
  input  wire logic       dut_oe,
  input  wire logic       peer_oe,
  input  wire logic [3:0] dut_lm,
  input  wire logic [3:0] peer_lm,
  output logic            line_n,
  output logic      [3:0] lm
);
  // open drain, any driver pulls low, pull-up otherwise
  assign line_n = !(dut_oe || peer_oe);
  // broadcast lines shared by all boards
  assign lm = dut_lm | peer_lm;
endmodule
